// >>> verilog/psam_top.v
// Purpose: forms program memory addresses and steers program data to the
//          core for fetches, table ops and the constant data window
// Assumes: one program word read per cycle, answer in the next cycle
// Notes:   registers reached over AHB-Lite, zero wait state slave
//          program and ram data must stand in the cycle after the request
//          edge, since the answer is registered on the following edge
// How it works
// R01: program address comes from counter, table address or window address
// R02: program words are two address units apart; counter steps by two
// R03: normal accesses stay below 0x800000; table page bit 7 picks config
// R04: address bit 23 set only for identifier and configuration accesses
// R05: table address is page byte over effective address; fetch clears 23,0
// R06: table read low word returns program bits 15..0
// R07: table read low byte picks bits 7..0 or 15..8 by byte select
// R08: table read high word gives bits 23..16 low, zero high byte
// R09: table read high byte gives bits 23..16, or zero for select one
// R10: window used only when address msb and window enable are both set
// R11: window address is visibility page over effective address bits 14..0
// R12: window reads return only the low sixteen program bits
// R13: the upper 32 Kbyte data half maps onto one 16K word page
// R14: window mapping is suspended during table reads and writes
// R15: multiply, transfer and double transfer window ops cost one extra cycle; multiply without mac_prefetch costs two here
// R16: other window reads cost two extra cycles outside a repeat loop
// R17: in repeat loops first, last, interrupt exit and reentry cost two
// R18: other repeat iterations of a window op take a single cycle
// R19: non multiply instructions see X as the whole 64 Kbyte range
// R20: multiply reads use Y pointers for Y block and X pointers for the rest
// R21: X and Y accessed together only by multiply class instructions
// R22: upper half of data space always belongs to X
// R23: unimplemented or wrong space accesses return zero; a mac read through a Y pointer that hits the window gets program data
//
// Added by the designer: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "psam_defs.vh"
`default_nettype none
module psam_top #(
	parameter [15:0] Y_BASE   = `PSAM_Y_BASE_RST,
	parameter [15:0] Y_END    = `PSAM_Y_END_RST,
	parameter [15:0] IMPL_END = `PSAM_IMPL_END_RST
) (
	// clock and reset
	input  wire        hclk,
	input  wire        hresetn,
	// ahb-lite slave
	input  wire        hsel,
	input  wire [11:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output reg  [31:0] hrdata,
	output reg         hreadyout,
	output reg         hresp,
	// instruction fetch request
	input  wire        fetch_req,
	input  wire        fetch_advance,
	input  wire        fetch_load,
	input  wire [22:0] fetch_load_pc,
	output reg  [22:0] prog_counter,
	// core data request
	input  wire        data_req,
	input  wire [2:0]  data_kind,
	input  wire        data_byte,
	input  wire [15:0] data_ea,
	input  wire        mac_instr,
	input  wire        mac_ptr_y,
	input  wire [15:0] mac_y_ea,
	input  wire        mac_y_req,
	input  wire [15:0] mem_rdata,
	input  wire [15:0] mem_y_rdata,
	// window cycle cost inputs
	input  wire [1:0]  instr_class,
	input  wire        mac_prefetch,
	input  wire        in_repeat,
	input  wire        rpt_first,
	input  wire        rpt_last,
	input  wire        rpt_irq_exit,
	input  wire        rpt_irq_reentry,
	// program memory
	input  wire [23:0] prog_rdata,
	output reg  [23:0] prog_addr,
	output reg         prog_rd,
	output reg         prog_wr_low,
	output reg         prog_wr_high,
	output reg  [15:0] prog_wdata,
	input  wire [15:0] tbl_wdata,
	// answers to the core
	output reg  [15:0] core_rdata,
	output reg         core_rvalid,
	output reg  [15:0] core_y_rdata,
	output reg         win_active,
	output reg  [1:0]  extra_cycles,
	output reg         data_to_ram,
	output reg  [15:0] ram_addr
);
	// registers
	reg [7:0]  core_control_reg;
	reg [7:0]  table_page_reg;
	reg [7:0]  visibility_page_reg;
	reg        rd_pend_reg;
	reg [2:0]  rd_kind_reg;
	reg        rd_byte_reg;
	reg        rd_zero_reg;
	reg        rd_prog_reg;
	reg        rd_y_zero_reg;
	reg        y_pend_reg;
	reg        bus_act_reg;
	reg        bus_wr_reg;
	reg [11:0] bus_addr_reg;
	reg [1:0]  win_cnt_reg;
	wire       const_window_enable;
	wire       tbl_op;
	wire       win_hit;
	wire       tbl_rd;
	wire [23:0] tbl_addr;
	wire [23:0] win_addr;
	wire [23:0] fetch_addr;
	wire       x_bad;
	wire       y_bad;
	reg [1:0]  extra_next;
	reg [15:0] steer_next;
	reg [31:0] rdata_next;
	// window enable is one bit of the core control register
	assign const_window_enable = core_control_reg[`PSAM_CTRL_WIN_BIT];
	// table op classes
	assign tbl_op = data_req && (data_kind != `PSAM_K_DATA);
	assign tbl_rd = data_req && ((data_kind == `PSAM_K_TRDL) ||
		(data_kind == `PSAM_K_TRDH));
	// window only for plain data access, never during table ops
	assign win_hit = data_req && (data_kind == `PSAM_K_DATA) &&
		data_ea[15] && const_window_enable; // R10 R13 R14 R22
	// table address: page byte over effective address, bit 23 from page
	assign tbl_addr = {table_page_reg, data_ea}; // R03 R04 R05
	// window address: bit 23 clear, page, low 15 ea bits
	assign win_addr = {1'b0, visibility_page_reg, data_ea[14:0]}; // R11 R13
	// fetch address: bits 23 and 0 forced clear
	assign fetch_addr = {1'b0, prog_counter[22:1], 1'b0}; // R04 R05
	// unimplemented low addresses read as zero; the upper half is left to
	// the ram side when the window is off, so it counts as implemented
	// mac x pointers may not reach Y block; y pointers only Y block
	assign x_bad = (data_ea > IMPL_END && !data_ea[15]) ||
		(mac_instr && mac_ptr_y) ||
		(mac_instr && data_ea >= Y_BASE && data_ea <= Y_END &&
		!data_ea[15]); // R19 R20 R22 R23
	assign y_bad = (mac_y_ea < Y_BASE) || (mac_y_ea > Y_END); // R20 R23
	// program counter steps two per word
	// bit 0 of a loaded counter is dropped so fetches stay word aligned
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			prog_counter <= 23'h000000;
		end else if (fetch_load) begin
			prog_counter <= {fetch_load_pc[22:1], 1'b0};
		end else if (fetch_advance) begin
			prog_counter <= prog_counter + 23'h000002; // R02
		end
	end
	// program memory address select and strobes
	// table ops win over the window, the window over ram, ram over fetch,
	// so a fetch simply waits while the core moves data
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			prog_addr    <= 24'h000000;
			prog_rd      <= 1'b0;
			prog_wr_low  <= 1'b0;
			prog_wr_high <= 1'b0;
			prog_wdata   <= 16'h0000;
			win_active   <= 1'b0;
			data_to_ram  <= 1'b0;
			ram_addr     <= 16'h0000;
		end else begin
			prog_rd      <= 1'b0;
			prog_wr_low  <= 1'b0;
			prog_wr_high <= 1'b0;
			data_to_ram  <= 1'b0;
			win_active   <= win_hit;
			if (tbl_op) begin
				prog_addr    <= tbl_addr; // R01
				prog_rd      <= tbl_rd;
				prog_wr_low  <= (data_kind == `PSAM_K_TWTL);
				prog_wr_high <= (data_kind == `PSAM_K_TWTH);
				prog_wdata   <= tbl_wdata;
			end else if (win_hit) begin
				prog_addr <= win_addr; // R01
				prog_rd   <= 1'b1;
			end else if (data_req) begin
				data_to_ram <= !x_bad;
				ram_addr    <= data_ea;
			end else if (fetch_req) begin
				prog_addr <= fetch_addr; // R01
				prog_rd   <= 1'b1;
			end
		end
	end
	// capture what the answer next cycle must look like
	// kind and byte select are kept so the steering below sees the
	// request that the program word belongs to
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rd_pend_reg   <= 1'b0;
			rd_kind_reg   <= `PSAM_K_DATA;
			rd_byte_reg   <= 1'b0;
			rd_zero_reg   <= 1'b0;
			rd_prog_reg   <= 1'b0;
			rd_y_zero_reg <= 1'b0;
			y_pend_reg    <= 1'b0;
		end else begin
			rd_pend_reg   <= data_req && (tbl_rd || win_hit ||
				data_kind == `PSAM_K_DATA);
			rd_kind_reg   <= data_kind;
			rd_byte_reg   <= data_byte;
			rd_prog_reg   <= tbl_rd || win_hit;
			rd_zero_reg   <= !tbl_rd && !win_hit && x_bad;
			// a Y read outside the multiply class gives zero, not stale data
			// simultaneous Y read only for multiply class
			y_pend_reg    <= mac_y_req && mac_instr; // R21
			rd_y_zero_reg <= y_bad || !mac_instr; // R21 R23
		end
	end
	// steering of program word onto the data path
	// table reads pick lanes, window reads keep the low word only
	always @* begin
		steer_next = 16'h0000;
		case (rd_kind_reg)
			`PSAM_K_TRDL: begin
				if (!rd_byte_reg) begin
					steer_next = prog_rdata[15:0]; // R06
				end else begin
					steer_next = {8'h00, prog_rdata[15:8]}; // R07
				end
			end
			`PSAM_K_TRDH: begin
				if (!rd_byte_reg) begin
					steer_next = {8'h00, prog_rdata[23:16]}; // R08 R09
				end else begin
					steer_next = 16'h0000; // R09
				end
			end
			default: begin
				steer_next = prog_rdata[15:0]; // R12
			end
		endcase
		// byte reads of the low table pick lane 0 by select 0
		if (rd_kind_reg == `PSAM_K_TRDL && !rd_byte_reg) begin
			steer_next = prog_rdata[15:0];
		end else if (rd_kind_reg == `PSAM_K_TRDL && rd_byte_reg) begin
			steer_next = {8'h00, prog_rdata[15:8]};
		end
	end
	// data returned to the core
	// zero forcing is never set for table or window reads, so a bad mac pointer that hits the window still gets program data
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			core_rdata   <= 16'h0000;
			core_rvalid  <= 1'b0;
			core_y_rdata <= 16'h0000;
		end else begin
			core_rvalid <= rd_pend_reg;
			if (rd_zero_reg) begin
				core_rdata <= 16'h0000; // R23
			end else if (rd_prog_reg) begin
				core_rdata <= steer_next;
			end else begin
				core_rdata <= mem_rdata;
			end
			if (y_pend_reg && !rd_y_zero_reg) begin
				core_y_rdata <= mem_y_rdata; // R20
			end else begin
				core_y_rdata <= 16'h0000; // R23
			end
		end
	end
	// extra cycle cost of a window access
	// the cost is shown one cycle after the access so the core can stall
	// for that many cycles before it retires the instruction
	always @* begin
		extra_next = 2'h0;
		if (win_hit) begin
			if (in_repeat) begin
				if (rpt_first || rpt_last || rpt_irq_exit ||
					rpt_irq_reentry) begin
					extra_next = `PSAM_EXTRA_TWO; // R17
				end else begin
					extra_next = 2'h0; // R18
				end
			end else begin
				case (instr_class)
					`PSAM_C_MAC: begin
						extra_next = mac_prefetch ? `PSAM_EXTRA_ONE :
							`PSAM_EXTRA_TWO; // R15 R16
					end
					`PSAM_C_MOV: begin
						extra_next = `PSAM_EXTRA_ONE; // R15
					end
					`PSAM_C_MOVD: begin
						extra_next = `PSAM_EXTRA_ONE; // R15
					end
					default: begin
						extra_next = `PSAM_EXTRA_TWO; // R16
					end
				endcase
			end
		end
	end
	// stall counter shown to the core
	// the status count saturates at three, it only shows that hits occur
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			extra_cycles <= 2'h0;
			win_cnt_reg  <= 2'h0;
		end else begin
			extra_cycles <= extra_next;
			if (win_hit && win_cnt_reg != 2'h3) begin
				win_cnt_reg <= win_cnt_reg + 2'h1;
			end
		end
	end
	// ahb-lite address phase capture
	// an address phase is only taken while the bus is ready
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			bus_act_reg  <= 1'b0;
			bus_wr_reg   <= 1'b0;
			bus_addr_reg <= 12'h000;
		end else if (hready) begin
			bus_act_reg  <= hsel && htrans[1];
			bus_wr_reg   <= hwrite;
			bus_addr_reg <= haddr;
		end
	end
	// register writes in the data phase
	// only the low byte of each register word is implemented
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			core_control_reg    <= `PSAM_CTRL_RST;
			table_page_reg      <= `PSAM_PAGE_RST;
			visibility_page_reg <= `PSAM_PAGE_RST;
		end else if (bus_act_reg && bus_wr_reg) begin
			case (bus_addr_reg)
				`PSAM_OFS_CORE_CTRL: core_control_reg <= hwdata[7:0];
				`PSAM_OFS_TBL_PAGE:  table_page_reg <= hwdata[7:0];
				`PSAM_OFS_VIS_PAGE:  visibility_page_reg <= hwdata[7:0];
				default: begin
				end
			endcase
		end
	end
	// read mux, unmapped reads give zero
	// read data is chosen from the live address phase
	always @* begin
		rdata_next = 32'h00000000;
		case (haddr)
			`PSAM_OFS_CORE_CTRL: rdata_next = {24'h000000, core_control_reg};
			`PSAM_OFS_TBL_PAGE:  rdata_next = {24'h000000, table_page_reg};
			`PSAM_OFS_VIS_PAGE:
				rdata_next = {24'h000000, visibility_page_reg};
			`PSAM_OFS_STATUS:
				rdata_next = {27'h0000000, win_cnt_reg, extra_cycles,
					win_active};
			default: rdata_next = 32'h00000000;
		endcase
	end
	// zero wait answer, read data registered at end of address phase
	// the slave never stretches a transfer and always answers okay
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata    <= 32'h00000000;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			if (hready && hsel && htrans[1] && !hwrite) begin
				hrdata <= rdata_next;
			end
		end
	end
endmodule // psam_top
`default_nettype wire

// >>> verilog/psam_defs.vh
// Purpose: constants for the program space access mapper
// Assumes: 32-bit AHB-Lite register words, byte addresses
// Notes:   offsets are byte addresses of aligned words
`ifndef PSAM_DEFS_VH
`define PSAM_DEFS_VH
// register byte offsets
`define PSAM_OFS_CORE_CTRL   12'h000
`define PSAM_OFS_TBL_PAGE    12'h004
`define PSAM_OFS_VIS_PAGE    12'h008
`define PSAM_OFS_STATUS      12'h00C
// field positions
`define PSAM_CTRL_WIN_BIT    2
// reset values
`define PSAM_CTRL_RST        8'h00
`define PSAM_PAGE_RST        8'h00
// access kinds
`define PSAM_K_DATA          3'h0
`define PSAM_K_TRDL          3'h1
`define PSAM_K_TRDH          3'h2
`define PSAM_K_TWTL          3'h3
`define PSAM_K_TWTH          3'h4
// instruction classes for window cost
`define PSAM_C_MAC           2'h0
`define PSAM_C_MOV           2'h1
`define PSAM_C_MOVD          2'h2
`define PSAM_C_OTHER         2'h3
// extra cycles
`define PSAM_EXTRA_ONE       2'h1
`define PSAM_EXTRA_TWO       2'h2
// data space limits
`define PSAM_Y_BASE_RST      16'h0800
`define PSAM_Y_END_RST       16'h0FFF
`define PSAM_IMPL_END_RST    16'h0FFF
`endif

// >>> dv/psam_chk_sva.sv
// Purpose: port level checks of the program space access mapper
// Assumes: requests are taken at the rising edge of hclk
// Notes:   bound to psam_top from the testbench file
`timescale 1ns/1ps
`include "psam_defs.vh"
`default_nettype none
module psam_chk (
	// clock and reset
	input wire        hclk,
	input wire        hresetn,
	// core requests
	input wire        fetch_req,
	input wire        fetch_advance,
	input wire        data_req,
	input wire [2:0]  data_kind,
	input wire [15:0] data_ea,
	// cost qualifiers
	input wire [1:0]  instr_class,
	input wire        mac_prefetch,
	input wire        in_repeat,
	input wire        rpt_first,
	input wire        rpt_last,
	input wire        rpt_irq_exit,
	input wire        rpt_irq_reentry,
	// mapper answers
	input wire [22:0] prog_counter,
	input wire [23:0] prog_addr,
	input wire        prog_rd,
	input wire        core_rvalid,
	input wire        win_active,
	input wire [1:0]  extra_cycles
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// request and cost classes
	wire rd0 = data_req && data_kind == `PSAM_K_DATA;
	wire tbl = data_req && data_kind != `PSAM_K_DATA;
	wire sp = rpt_first | rpt_last | rpt_irq_exit | rpt_irq_reentry;
	wire one = !in_repeat && (instr_class == `PSAM_C_MOV ||
		instr_class == `PSAM_C_MOVD ||
		(instr_class == `PSAM_C_MAC && mac_prefetch));
	wire two = (!in_repeat && !one) || (in_repeat && sp);
	sequence s_cost(logic c);
		rd0 && c ##1 win_active;
	endsequence
	property p_fetch;
		fetch_req && !data_req |=> prog_rd &&
			prog_addr == {1'b0, $past(prog_counter[22:1]), 1'b0};
	endproperty
	a_fetch: assert property (p_fetch) else $error("fetch address");
	property p_step;
		fetch_advance |=> prog_counter == $past(prog_counter) + 23'h2;
	endproperty
	a_step: assert property (p_step) else $error("pc step");
	property p_tbl;
		tbl |=> !win_active && prog_addr[15:0] == $past(data_ea);
	endproperty
	a_tbl: assert property (p_tbl) else $error("table address");
	property p_win;
		s_cost(1'b1) |-> !prog_addr[23] &&
			prog_addr[14:0] == $past(data_ea[14:0], 1);
	endproperty
	a_win: assert property (p_win) else $error("window address");
	property p_msb;
		rd0 && !data_ea[15] |=> !win_active;
	endproperty
	a_msb: assert property (p_msb) else $error("window hit");
	property p_c1;
		s_cost(one) |-> extra_cycles == `PSAM_EXTRA_ONE;
	endproperty
	a_c1: assert property (p_c1) else $error("cost one");
	property p_c2;
		s_cost(two) |-> extra_cycles == `PSAM_EXTRA_TWO;
	endproperty
	a_c2: assert property (p_c2) else $error("cost two");
	property p_c0;
		s_cost(in_repeat && !sp) |-> extra_cycles == 2'h0;
	endproperty
	a_c0: assert property (p_c0) else $error("cost none");
	property p_ans;
		data_req && data_kind < `PSAM_K_TWTL |-> ##2 core_rvalid;
	endproperty
	a_ans: assert property (p_ans) else $error("no answer");
endmodule // psam_chk
`default_nettype wire

// >>> dv/psam_mem_model.sv
// Purpose: program memory and data ram behind the mapper
// Assumes: data stands while the registered request stands
// Notes:   idle data lines show the inverse of the last value
`timescale 1ns/1ps
`default_nettype none
module psam_mem_model (
	// clock
	input  wire logic        hclk,
	// program memory
	input  wire logic        prog_rd,
	input  wire logic [23:0] prog_addr,
	output var  logic [23:0] prog_rdata,
	// data ram
	input  wire logic        data_to_ram,
	input  wire logic [15:0] ram_addr,
	input  wire logic        mac_y_req,
	input  wire logic [15:0] mac_y_ea,
	output var  logic [15:0] mem_rdata,
	output var  logic [15:0] mem_y_rdata
);
	logic        y_reg = 1'b0;
	logic [15:0] ya_reg = 16'h0000;
	logic [23:0] p_last = 24'h000000;
	logic [15:0] m_last = 16'h0000;
	logic [15:0] y_last = 16'h0000;
	// contents are address patterns, garbled when not asked
	assign prog_rdata = prog_rd ? {prog_addr[7:0] ^ prog_addr[23:16],
		prog_addr[15:0] ^ 16'hC3A5} : ~p_last;
	assign mem_rdata = data_to_ram ? ram_addr ^ 16'h6E19 : ~m_last;
	assign mem_y_rdata = y_reg ? ya_reg ^ 16'h6E19 : ~y_last;
	// last shown values, and the Y request taken at the core's edge
	always @(posedge hclk) begin
		p_last <= prog_rdata;
		m_last <= mem_rdata;
		y_last <= mem_y_rdata;
		y_reg <= mac_y_req;
		ya_reg <= mac_y_ea;
	end
endmodule // psam_mem_model
`default_nettype wire

// >>> dv/testbench.sv
// Purpose: self checking bench of the program space access mapper
// Assumes: zero wait state register bus
// Notes:   reset reads first, then table rows, fetch, write, cost and mac cases, then a second reset
`timescale 1ns/1ps
`include "psam_defs.vh"
`default_nettype none
module testbench;
	logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
	logic [11:0] haddr = 0;
	logic [1:0] htrans = 0, instr_class = 2'h1, extra_cycles;
	logic [2:0] hsize = 3'h2, data_kind = 0;
	logic [31:0] hwdata = 0, hrdata, q;
	logic fetch_req = 0, fetch_advance = 0, fetch_load = 0, data_req = 0;
	logic data_byte = 0, mac_instr = 0, mac_ptr_y = 0, mac_y_req = 0;
	logic mac_prefetch = 0, in_repeat = 0, rpt_first = 0, rpt_last = 0;
	logic rpt_irq_exit = 0, rpt_irq_reentry = 0, hreadyout, hresp;
	logic [22:0] fetch_load_pc = 0, prog_counter;
	logic [15:0] data_ea = 0, mac_y_ea = 0, tbl_wdata = 0, mem_rdata;
	logic [15:0] mem_y_rdata, prog_wdata, core_rdata, core_y_rdata, ram_addr;
	logic [15:0] rd, ra, wd, yd, ea, m;
	logic [23:0] prog_rdata, prog_addr, pa, xa;
	logic prog_rd, prog_wr_low, prog_wr_high, core_rvalid, win_active;
	logic data_to_ram, wa, b, w, hit;
	logic [1:0] xc, wr;
	logic [2:0] k;
	logic [7:0] tp, vp;
	int errors = 0, tests_run = 0, i, p;
	wire hready = hreadyout;
	logic [20:0] rows [10] = '{{3'h1, 1'b0, 16'h1234, 1'b1},
		{3'h1, 1'b1, 16'h1235, 1'b0}, {3'h2, 1'b0, 16'h0246, 1'b1},
		{3'h2, 1'b1, 16'h0247, 1'b0}, {3'h1, 1'b0, 16'h8004, 1'b1},
		{3'h0, 1'b0, 16'h8ABC, 1'b1}, {3'h0, 1'b0, 16'hFFFE, 1'b1},
		{3'h0, 1'b0, 16'h8ABC, 1'b0}, {3'h0, 1'b0, 16'h0900, 1'b1},
		{3'h0, 1'b0, 16'h2000, 1'b0}};
	logic [9:0] costs [10] = '{10'h085, 10'h105, 10'h205, 10'h306,
		10'h006, 10'h162, 10'h152, 10'h14A, 10'h146, 10'h140};
	psam_top i_dut (.*);
	psam_mem_model i_mem (.*);
	always #20 hclk = ~hclk;
	// program word pattern held by the memory model
	function automatic logic [23:0] pw(input logic [23:0] a);
		return {a[7:0] ^ a[23:16], a[15:0] ^ 16'hC3A5};
	endfunction
	// expected core data for one access
	function automatic logic [15:0] ex(input logic [15:0] e);
		logic [23:0] v;
		v = pw(k ? {tp, e} : {1'b0, vp, e[14:0]});
		if (k == 1) return b ? {8'h00, v[15:8]} : v[15:0];
		if (k == 2) return b ? 16'h0000 : {8'h00, v[23:16]};
		if (hit) return v[15:0];
		return (e < 16'h1000 || e[15]) ? e ^ 16'h6E19 : 16'h0000;
	endfunction
	task automatic chk(input string s, input logic [31:0] e, g);
		tests_run++;
		if (g !== e) begin
			errors++;
			$display("[ERR] %s exp %h got %h", s, e, g);
		end
	endtask
	// one ahb-lite single word transfer
	task automatic bus(input logic wt, input logic [11:0] a,
		input logic [31:0] d);
		hsel <= 1;
		htrans <= 2'h2;
		hwrite <= wt;
		haddr <= a;
		do @(posedge hclk); while (hready !== 1'b1);
		hsel <= 0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1);
		q = hrdata;
	endtask
	// one core data request and its answers
	task automatic req(input logic [2:0] kk, input logic bb,
		input logic [15:0] e);
		int n = 0;
		data_kind <= kk;
		data_byte <= bb;
		data_ea <= e;
		data_req <= 1;
		@(posedge hclk);
		data_req <= 0;
		mac_y_req <= 0;
		#1;
		{pa, wa, xc, ra, wr, wd} = {prog_addr, win_active, extra_cycles,
			ram_addr, prog_wr_high, prog_wr_low, prog_wdata};
		while (core_rvalid !== 1'b1 && n++ < 5) @(posedge hclk) #1;
		chk("rvalid", kk < 3'h3, core_rvalid);
		{rd, yd} = {core_rdata, core_y_rdata};
		@(posedge hclk);
	endtask
	task automatic close_out;
		$display("comparisons %0d mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial begin
		#300000;
		errors++;
		close_out;
	end
	initial begin
		repeat (6) @(posedge hclk);
		hresetn <= 1;
		@(posedge hclk);
		for (i = 0; i < 4; i++) begin
			bus(0, i * 12'h004 + (i == 3) * 12'h0F0, 0);
			chk("reset reg", 0, q);
		end
		bus(1, 12'h0F0, 32'hFF);
		bus(0, 12'h0F0, 0);
		chk("unmapped", 0, q);
		$display("reset test done");
		for (p = 0; p < 2; p++) begin
			tp = p ? 8'h80 : 8'h01;
			vp = p ? 8'hFF : 8'h5A;
			bus(1, `PSAM_OFS_TBL_PAGE, {24'h0, tp});
			bus(1, `PSAM_OFS_VIS_PAGE, {24'h0, vp});
			for (i = 0; i < 10; i++) begin
				{k, b, ea, w} = rows[i];
				bus(1, `PSAM_OFS_CORE_CTRL, {29'h0, w, 2'h0});
				req(k, b, ea);
				hit = k == 0 && w && ea[15];
				m = b ? 16'h00FF : 16'hFFFF;
				chk("data", ex(ea) & m, rd & m);
				xa = k ? {tp, ea} : hit ? {1'b0, vp, ea[14:0]} : {8'h00, ea};
				chk("addr", xa, (k || hit) ? pa : {8'h00, ra});
				chk("win", hit, wa);
			end
		end
		$display("row test done");
		fetch_load_pc <= 23'h12345;
		fetch_load <= 1;
		@(posedge hclk);
		fetch_load <= 0;
		fetch_advance <= 1;
		repeat (3) @(posedge hclk);
		fetch_advance <= 0;
		fetch_req <= 1;
		@(posedge hclk);
		fetch_req <= 0;
		#1;
		chk("pc", 23'h1234A, prog_counter);
		chk("fetch addr", 24'h01234A, prog_addr);
		@(posedge hclk);
		tbl_wdata <= 16'hBEEF;
		for (i = 3; i < 5; i++) begin
			req(i[2:0], 0, 16'h0010);
			chk("write", i - 2, wr);
			chk("wdata", 16'hBEEF, wd);
		end
		$display("fetch and write test done");
		bus(1, `PSAM_OFS_CORE_CTRL, 32'h4);
		for (i = 0; i < 10; i++) begin
			{instr_class, mac_prefetch, in_repeat, rpt_first, rpt_last,
				rpt_irq_exit, rpt_irq_reentry} <= costs[i][9:2];
			mac_instr <= costs[i][9:8] == 2'h0;
			req(0, 0, 16'h8100);
			chk("extra", costs[i][1:0], xc);
		end
		bus(0, `PSAM_OFS_STATUS, 0);
		chk("status", 32'h00000018, q);
		{instr_class, in_repeat, mac_instr} <= 4'h1;
		$display("cost test done");
		for (i = 0; i < 4; i++) begin
			mac_ptr_y <= i[1];
			mac_y_req <= 1;
			mac_y_ea <= i[1] ? 16'h0100 : 16'h0902;
			req(0, 0, i[0] ? 16'h0100 : 16'h0904);
			chk("mac x", (i == 1) ? 16'h0100 ^ 16'h6E19 : 0, rd);
			chk("mac y", i[1] ? 0 : 16'h0902 ^ 16'h6E19, yd);
		end
		$display("mac test done");
		hresetn <= 0;
		@(posedge hclk);
		hresetn <= 1;
		#1;
		chk("reset pc", 0, prog_counter);
		@(posedge hclk);
		bus(0, `PSAM_OFS_CORE_CTRL, 0);
		chk("reset ctrl", 0, q);
		$display("second reset test done");
		close_out;
	end
endmodule // testbench
bind psam_top psam_chk i_chk (.*);
`default_nettype wire
